// >>> pom_consts.vh
// constants for the port output function mux
`ifndef POM_CONSTS_VH
`define POM_CONSTS_VH
`define POM_ADDR_W 10
`define POM_OFS_SEL_A6 10'h3B0
`define POM_OFS_SEL_A7 10'h3B1
`define POM_OFS_SEL_A8 10'h3B4
`define POM_OFS_SEL_A9 10'h3B5
`define POM_OFS_SEL_B6 10'h3B8
`define POM_OFS_SEL_B7 10'h3B9
`define POM_OFS_SEL_B8 10'h3BA
`define POM_OFS_SEL_B9 10'h3BB
`define POM_OFS_SEL_C 10'h3AF
`define POM_OFS_FORMAT 10'h3FF
`define POM_OFS_PROTECT 10'h00A
`define POM_OFS_KEYCTL 10'h093
`define POM_RST_SEL 8'h00
`define POM_RST_SEL_B7 8'h40
`define POM_SEL_A8_MASK 8'h03
`define POM_SEL_C_MASK 8'h9F
`define POM_SEL_B7_MASK 8'h7F
`define POM_PROT_EN_BIT 2
`define POM_ISO_BIT 7
`define POM_KEY_IR_BIT 3
`define POM_UNDEF_READ 4'h0
`endif

// >>> pom_pin_cell.v
// one pin cell: output source, enable and format
`timescale 1ns/10ps
module pom_pin_cell (
    input wire sel_periph_i,
    input wire periph_out_i,
    input wire latch_i,
    input wire dir_i,
    input wire open_drain_i,
    output wire pin_o,
    output wire pin_oe_o
);
    // port latch and direction rule while peripheral use is off
    wire val = sel_periph_i ? periph_out_i : latch_i;
    wire drv = sel_periph_i | dir_i;
    assign pin_o = val;
    // open drain: only a low level is driven, the p-channel stays off
    assign pin_oe_o = drv & ~(open_drain_i & val);
endmodule

// >>> pom_top.v
// register file and pin routing for ports 1 and 6 to 10
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "pom_consts.vh"
module pom_top (
    input wire REF_CLK_I,
    input wire RST_B_I,
    input wire [`POM_ADDR_W-1:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [7:0] RDATA_O,
    input wire [7:0] P1_LATCH_I,
    input wire [7:0] P1_DIR_I,
    input wire [39:0] PX_LATCH_I,
    input wire [39:0] PX_DIR_I,
    input wire [39:0] PX_PIN_I,
    input wire [39:0] PERIPH_OUT_A_I,
    input wire [39:0] PERIPH_OUT_B_I,
    input wire [39:0] PERIPH_OUT_C_I,
    input wire KEY_EDGE_I,
    output reg [7:0] P1_PIN_O,
    output reg [7:0] P1_PIN_OE_O,
    output reg [39:0] PX_PIN_O,
    output reg [39:0] PX_PIN_OE_O,
    output reg [39:0] PERIPH_IN_O,
    output reg [7:0] PORT10_READ_O,
    output reg [5:0] ANALOG_CONNECT_O,
    output reg KEY_IR_O
);
    // pin vector order: port 6 bits 0-7, port 7 8-15, port 8 16-23, port 9 24-31, port 10 32-39
    reg [7:0] sel_a6_ff;
    reg [7:0] sel_a7_ff;
    reg [7:0] sel_a8_ff;
    reg [7:0] sel_a9_ff;
    reg [7:0] sel_b6_ff;
    reg [7:0] sel_b7_ff;
    reg [7:0] sel_b8_ff;
    reg [7:0] sel_b9_ff;
    reg [7:0] sel_c_ff;
    reg fmt_ff;
    reg prot_en_ff;
    reg key_ir_ff;
    reg [7:0] nxt_rdata;
    wire iso10 = sel_c_ff[`POM_ISO_BIT];
    wire wr_a9 = WR_I & (ADDR_I == `POM_OFS_SEL_A9);
    wire wr_key = WR_I & (ADDR_I == `POM_OFS_KEYCTL);

    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sel_a6_ff <= `POM_RST_SEL;
            sel_a7_ff <= `POM_RST_SEL;
            sel_a8_ff <= `POM_RST_SEL;
            sel_a9_ff <= `POM_RST_SEL;
            sel_b6_ff <= `POM_RST_SEL;
            sel_b7_ff <= `POM_RST_SEL_B7;
            sel_b8_ff <= `POM_RST_SEL;
            sel_b9_ff <= `POM_RST_SEL;
            sel_c_ff <= `POM_RST_SEL;
            fmt_ff <= 1'b0;
            prot_en_ff <= 1'b0;
            key_ir_ff <= 1'b0;
        end else begin
            if (WR_I) begin
                case (ADDR_I)
                    `POM_OFS_SEL_A6: sel_a6_ff <= WDATA_I;
                    // select-A bit 7 of port 7 has no output function
                    `POM_OFS_SEL_A7: sel_a7_ff <= WDATA_I & `POM_SEL_B7_MASK;
                    `POM_OFS_SEL_A8: sel_a8_ff <= WDATA_I & `POM_SEL_A8_MASK;
                    `POM_OFS_SEL_B6: sel_b6_ff <= WDATA_I;
                    `POM_OFS_SEL_B7: sel_b7_ff <= WDATA_I & `POM_SEL_B7_MASK;
                    `POM_OFS_SEL_B8: sel_b8_ff <= WDATA_I;
                    `POM_OFS_SEL_B9: sel_b9_ff <= WDATA_I;
                    `POM_OFS_SEL_C: sel_c_ff <= WDATA_I & `POM_SEL_C_MASK;
                    `POM_OFS_FORMAT: fmt_ff <= WDATA_I[0];
                    default: begin
                    end
                endcase
            end
            // the enable admits one write to select-A 9, then closes
            if (WR_I && ADDR_I == `POM_OFS_PROTECT) begin
                prot_en_ff <= WDATA_I[`POM_PROT_EN_BIT];
            end else if (wr_a9) begin
                prot_en_ff <= 1'b0;
            end
            if (wr_a9 && prot_en_ff) begin
                sel_a9_ff <= WDATA_I;
            end
            // set wins over a software clear; isolation forces the flag clear
            if (iso10) begin
                key_ir_ff <= 1'b0;
            end else if (KEY_EDGE_I) begin
                key_ir_ff <= 1'b1;
            end else if (wr_key && !WDATA_I[`POM_KEY_IR_BIT]) begin
                key_ir_ff <= 1'b0;
            end
        end
    end

    always @* begin
        nxt_rdata = 8'h00;
        if (RD_I) begin
            case (ADDR_I)
                `POM_OFS_SEL_A6: nxt_rdata = sel_a6_ff;
                `POM_OFS_SEL_A7: nxt_rdata = sel_a7_ff;
                `POM_OFS_SEL_A8: nxt_rdata = sel_a8_ff;
                `POM_OFS_SEL_A9: nxt_rdata = sel_a9_ff;
                `POM_OFS_SEL_B6: nxt_rdata = sel_b6_ff;
                `POM_OFS_SEL_B7: nxt_rdata = sel_b7_ff;
                `POM_OFS_SEL_B8: nxt_rdata = sel_b8_ff;
                `POM_OFS_SEL_B9: nxt_rdata = sel_b9_ff;
                `POM_OFS_SEL_C: nxt_rdata = sel_c_ff;
                `POM_OFS_FORMAT: nxt_rdata = {7'h00, fmt_ff};
                `POM_OFS_PROTECT: nxt_rdata = {5'h00, prot_en_ff, 2'h0};
                `POM_OFS_KEYCTL: nxt_rdata = {4'h0, key_ir_ff, 3'h0};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // per-pin select-A and select-B, c for the port 7 / port 10 select-C
    wire [39:0] sel_a = {8'h00, sel_a9_ff, sel_a8_ff, sel_a7_ff, sel_a6_ff};
    wire [39:0] sel_b = {8'h00, sel_b9_ff, sel_b8_ff, sel_b7_ff, sel_b6_ff};
    wire [39:0] sel_c = {24'h000000, sel_c_ff, 8'h00};
    // analog isolation per pin: p9_3..p9_6 via select-B 9 bits 3-6, p10_4..p10_7 via select-C 7
    wire [39:0] iso = {{4{iso10}}, 4'h0, 1'b0, sel_b9_ff[6:3], 3'h0, 24'h000000};
    reg [39:0] p_val;
    integer k;

    // source choice: a = first alternative, b = select-B bit set except on p9_3..p9_6, c = select-C bit set on port 7 bits 0-4 with select-B clear
    always @* begin
        for (k = 0; k < 40; k = k + 1) begin
            if (k >= 8 && k < 13) begin
                p_val[k] = sel_b[k] ? PERIPH_OUT_B_I[k] :
                    (sel_c[k] ? PERIPH_OUT_C_I[k] : PERIPH_OUT_A_I[k]);
            end else if (k >= 27 && k < 31) begin
                p_val[k] = PERIPH_OUT_A_I[k];
            end else begin
                p_val[k] = sel_b[k] ? PERIPH_OUT_B_I[k] : PERIPH_OUT_A_I[k];
            end
        end
    end

    wire [39:0] px_pin;
    wire [39:0] px_oe;
    wire [7:0] p1_pin;
    wire [7:0] p1_oe;
    genvar g;
    generate
        for (g = 0; g < 48; g = g + 1) begin : g_pin
            if (g < 40) begin : g_px
                pom_pin_cell u_cell (
                    .sel_periph_i(sel_a[g]),
                    .periph_out_i(p_val[g]),
                    .latch_i(PX_LATCH_I[g]),
                    .dir_i(PX_DIR_I[g]),
                    .open_drain_i(1'b0),
                    .pin_o(px_pin[g]),
                    .pin_oe_o(px_oe[g])
                );
            end else begin : g_p1
                pom_pin_cell u_cell (
                    .sel_periph_i(1'b0),
                    .periph_out_i(1'b0),
                    .latch_i(P1_LATCH_I[g-40]),
                    .dir_i(P1_DIR_I[g-40]),
                    .open_drain_i(fmt_ff),
                    .pin_o(p1_pin[g-40]),
                    .pin_oe_o(p1_oe[g-40])
                );
            end
        end
    endgenerate

    // dac and analog pins stop driving as digital outputs when isolated
    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            RDATA_O <= 8'h00;
            P1_PIN_O <= 8'h00;
            P1_PIN_OE_O <= 8'h00;
            PX_PIN_O <= 40'h0000000000;
            PX_PIN_OE_O <= 40'h0000000000;
            PERIPH_IN_O <= 40'h0000000000;
            PORT10_READ_O <= 8'h00;
            ANALOG_CONNECT_O <= 6'h00;
            KEY_IR_O <= 1'b0;
        end else begin
            RDATA_O <= nxt_rdata;
            P1_PIN_O <= p1_pin;
            P1_PIN_OE_O <= p1_oe;
            PX_PIN_O <= px_pin;
            PX_PIN_OE_O <= px_oe & ~iso;
            PERIPH_IN_O <= PX_PIN_I & ~iso;
            // undefined bits are shown as a fixed zero
            PORT10_READ_O <= iso10 ? {`POM_UNDEF_READ, PX_PIN_I[35:32]} : PX_PIN_I[39:32];
            ANALOG_CONNECT_O <= {sel_b9_ff[6:3], iso10, iso10};
            KEY_IR_O <= key_ir_ff & ~iso10;
        end
    end
endmodule

// >>> pom_top_asserts.sv
// checker for the port output function mux, bound to the top module
`timescale 1ns/10ps
`include "pom_consts.vh"
module pom_top_asserts (
    input wire REF_CLK_I,
    input wire RST_B_I,
    input wire [`POM_ADDR_W-1:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire [7:0] RDATA_O,
    input wire [39:0] PX_DIR_I,
    input wire [39:0] PERIPH_OUT_A_I,
    input wire [39:0] PERIPH_OUT_B_I,
    input wire [7:0] P1_PIN_O,
    input wire [7:0] P1_PIN_OE_O,
    input wire [39:0] PX_PIN_O,
    input wire [39:0] PX_PIN_OE_O,
    input wire [39:0] PERIPH_IN_O,
    input wire [7:0] PORT10_READ_O,
    input wire [5:0] ANALOG_CONNECT_O,
    input wire KEY_IR_O
);
    reg fmt_ff, prot_ff;
    reg [7:0] a8_ff, b8_ff, a9_ff, b9_ff, c_ff;
    // shadow copies of the select registers, updated on the write edge
    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            {fmt_ff, prot_ff, a8_ff, b8_ff, a9_ff, b9_ff, c_ff} <= 42'h0;
        end else if (WR_I) begin
            if (ADDR_I == 10'h3FF) fmt_ff <= WDATA_I[0];
            if (ADDR_I == 10'h3B4) a8_ff <= WDATA_I & 8'h03;
            if (ADDR_I == 10'h3BA) b8_ff <= WDATA_I;
            if (ADDR_I == 10'h3BB) b9_ff <= WDATA_I;
            if (ADDR_I == 10'h3AF) c_ff <= WDATA_I & 8'h9F;
            if (ADDR_I == 10'h00A) prot_ff <= WDATA_I[2];
            // any write to the guarded register uses up the enable
            if (ADDR_I == 10'h3B5) begin
                prot_ff <= 1'b0;
                if (prot_ff) a9_ff <= WDATA_I;
            end
        end
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);
    // pins lag the registers by one edge, so each pin check waits for a stable setting
    od_p1_a: assert property (
        fmt_ff && $stable(fmt_ff) |-> (P1_PIN_O & P1_PIN_OE_O) == 8'h00) else $error("p1 high drive");
    key_hold_a: assert property (
        c_ff[7] && $stable(c_ff[7]) |-> !KEY_IR_O) else $error("key flag set while isolated");
    p10_cut_a: assert property (
        c_ff[7] && $stable(c_ff[7]) |-> {PORT10_READ_O[7:4], PERIPH_IN_O[39:36]} == 8'h00)
        else $error("port 10 input not cut");
    an_conn_a: assert property (
        $stable(c_ff[7]) |-> ANALOG_CONNECT_O[1:0] == {2{c_ff[7]}}) else $error("analog 4-7 link");
    dac_conn_a: assert property (
        $stable(b9_ff) |-> ANALOG_CONNECT_O[5:2] == b9_ff[6:3]) else $error("dac or ext link");
    rd_idle_a: assert property (
        !$past(RD_I) |-> RDATA_O == 8'h00) else $error("read data outside read cycle");
    a9_read_a: assert property (
        RD_I && ADDR_I == 10'h3B5 |=> RDATA_O == $past(a9_ff)) else $error("guarded write leak");
    p8_port_a: assert property (
        !a8_ff[0] && $stable(a8_ff[0]) |-> PX_PIN_OE_O[16] == $past(PX_DIR_I[16]))
        else $error("p8_0 enable not from direction");
    p8_sel_a: assert property (
        a8_ff[0] && $stable(a8_ff[0]) && $stable(b8_ff[0]) |-> PX_PIN_O[16] ==
        (b8_ff[0] ? $past(PERIPH_OUT_B_I[16]) : $past(PERIPH_OUT_A_I[16]))) else $error("p8_0 mux");
    cover property (a9_ff == 8'h08);
    cover property (KEY_IR_O);
    cover property (fmt_ff && P1_PIN_OE_O != 8'h00);
endmodule
bind pom_top pom_top_asserts u_pom_top_asserts (.*);

// >>> pom_pins_model.sv
// far-side pins: outside sources on undriven pins, key-pin change events
`timescale 1ns/10ps
module pom_pins_model (
    input wire clk_i,
    input wire [39:0] pin_o_i,
    input wire [39:0] oe_i,
    input wire [39:0] ext_i,
    output wire [39:0] pin_i_o,
    output reg key_edge_o = 1'b0
);
    reg [3:0] last_ff = 4'h0;
    // a driven pin shows its driver, an undriven one the outside source
    assign pin_i_o = (pin_o_i & oe_i) | (ext_i & ~oe_i);
    always @(posedge clk_i) begin
        key_edge_o <= (pin_i_o[39:36] != last_ff);
        last_ff <= pin_i_o[39:36];
    end
endmodule

// >>> pom_top_tb.sv
// testbench for the port output function mux
`timescale 1ns/10ps
module pom_top_tb;
    reg clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    reg [9:0] addr = 10'h000;
    reg [7:0] wdata = 8'h00, p1_latch = 8'h55, p1_dir = 8'hFF;
    reg [39:0] latch = 40'h0, dir = 40'h0, pa = 40'h0, pb = 40'h0, pc = 40'h0, ext = 40'h0;
    wire [7:0] rdata, p1_pin, p1_oe, p10_rd;
    wire [39:0] pin_o, pin_oe, pin_i, per_in;
    wire [5:0] an_con;
    wire key_edge, key_ir;
    integer mismatches = 0, n_tests = 0, cyc = 0;
    initial forever #12.5 clk = ~clk;
    pom_top u_pom_top (.REF_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .P1_LATCH_I(p1_latch), .P1_DIR_I(p1_dir),
        .PX_LATCH_I(latch), .PX_DIR_I(dir), .PX_PIN_I(pin_i), .PERIPH_OUT_A_I(pa),
        .PERIPH_OUT_B_I(pb), .PERIPH_OUT_C_I(pc), .KEY_EDGE_I(key_edge), .P1_PIN_O(p1_pin),
        .P1_PIN_OE_O(p1_oe), .PX_PIN_O(pin_o), .PX_PIN_OE_O(pin_oe), .PERIPH_IN_O(per_in),
        .PORT10_READ_O(p10_rd), .ANALOG_CONNECT_O(an_con), .KEY_IR_O(key_ir));
    pom_pins_model u_pom_pins_model (.clk_i(clk), .pin_o_i(pin_o), .oe_i(pin_oe),
        .ext_i(ext), .pin_i_o(pin_i), .key_edge_o(key_edge));
    task chk(input [39:0] got, input [39:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr_reg(input [9:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_chk(input [9:0] a, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk(rdata, e);
        end
    endtask
    // pins show a new setting one edge after it lands, so two edges are enough
    task settle;
        begin
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task pins(input [39:0] l, input [39:0] d, input [39:0] a, input [39:0] b);
        begin
            @(posedge clk);
            latch <= l;
            dir <= d;
            pa <= a;
            pb <= b;
            settle;
        end
    endtask
    task results;
        begin
            if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // the whole run takes well under a thousand cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            mismatches = mismatches + 1;
            results;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(10'h3B9, 8'h40);
        rd_chk(10'h100, 8'h00);
        wr_reg(10'h3B5, 8'h08);
        rd_chk(10'h3B5, 8'h00);
        wr_reg(10'h00A, 8'h04);
        wr_reg(10'h3B5, 8'h08);
        rd_chk(10'h3B5, 8'h08);
        wr_reg(10'h3B5, 8'hFF);
        rd_chk(10'h3B5, 8'h08);
        wr_reg(10'h3B4, 8'hFF);
        rd_chk(10'h3B4, 8'h03);
        pins(40'h0, 40'h00FFFFFFFF, 40'h0008010000, 40'h0);
        chk({pin_oe[16], pin_o[16]}, 2'b11);
        chk(pin_o[27], 1'b1);
        wr_reg(10'h3BA, 8'h01);
        pins(40'h0, 40'h00FFFFFFFF, 40'h0, 40'h0000010000);
        chk(pin_o[16], 1'b1);
        wr_reg(10'h3B4, 8'h00);
        pins(40'h0000010000, 40'h0, 40'h0000010000, 40'h0);
        chk(pin_oe[16], 1'b0);
        pins(40'h0000010000, 40'h0000010000, 40'h0, 40'h0);
        chk({pin_oe[16], pin_o[16]}, 2'b11);
        chk({p1_oe, p1_pin}, 16'hFF55);
        wr_reg(10'h3FF, 8'h01);
        settle;
        chk({p1_oe, p1_pin & p1_oe}, 16'hAA00);
        wr_reg(10'h3FF, 8'h00);
        @(posedge clk);
        ext <= 40'h1000000000;
        // the model needs one edge to see the change, the flag two more to show it
        @(posedge clk);
        settle;
        chk(key_ir, 1'b1);
        wr_reg(10'h093, 8'h00);
        settle;
        chk(key_ir, 1'b0);
        wr_reg(10'h3AF, 8'hFF);
        rd_chk(10'h3AF, 8'h9F);
        // high levels and a key change while isolated, so a leak would show
        @(posedge clk);
        ext <= 40'hF000000000;
        settle;
        settle;
        chk({key_ir, p10_rd[7:4], per_in[39:36], an_con[1:0]}, 11'h003);
        wr_reg(10'h3B1, 8'h04);
        @(posedge clk);
        pc <= 40'h0000000400;
        settle;
        chk(pin_o[10], 1'b1);
        wr_reg(10'h3BB, 8'h78);
        settle;
        chk(an_con[5:2], 4'hF);
        chk(pin_oe[30:27], 4'h0);
        results;
    end
endmodule
